// ==== hw/barrier_pkg.sv ====
// Purpose: constants and types for the memory barrier control unit
// Assumes: 32-bit instruction word, AHB-Lite register access
// Notes: offsets are byte addresses, one register per word
// Functional notes
// - ordering bit 3 keeps later stores back until earlier stores are visible
// - ordering bit 2 keeps later stores back until earlier loads are performed
// - ordering bit 1 keeps later loads back until earlier stores are visible
// - ordering bit 0 keeps later loads back until earlier loads are performed
// - completion mask comes from instruction bits 6 down to 4
// - zero completion mask gives partial ordering only, else completion too
// - completion bit 2 drains all work and errors before any later issue
// - completion bit 1 drains all memory work before later memory access
// - completion bit 0 holds later loads until earlier stores complete
// - both masks zero behaves as a no-operation
// - nonzero reserved bits 11 to 7 raise an illegal-instruction exception
// - barrier recognised by source 15, destination 0, immediate 1, bit 12 clear
// - ordering mask 8 with zero completion equals the legacy write barrier
// - strong ordering mode drops three orderings, promotes others to full sync
// - any realisation is allowed that keeps the ordering semantics
// - full sync completes all work and reports errors before next issue
// - alternate-space access with a sync identifier also forces full sync
// - sync does not wait for store data to reach external memory
// - ordering mask comes from instruction bits 3 down to 0, any mix
// - constraints cover all own address spaces, never other processors
package barrier_pkg;
   localparam int OP_MSB = 31;
   localparam int OP_LSB = 30;
   localparam int RD_MSB = 29;
   localparam int RD_LSB = 25;
   localparam int OP3_MSB = 24;
   localparam int OP3_LSB = 19;
   localparam int RS1_MSB = 18;
   localparam int RS1_LSB = 14;
   localparam int IMM_BIT = 13;
   localparam int RSV_MSB = 12;
   localparam int RSV_LSB = 7;
   localparam int CM_MSB = 6;
   localparam int CM_LSB = 4;
   localparam int MM_MSB = 3;
   localparam int MM_LSB = 0;
   localparam logic [4:0] RS1_BARRIER = 5'h0f;
   localparam logic [4:0] RD_BARRIER = 5'h00;
   localparam logic [3:0] LEGACY_WB_MM = 4'h8;
   localparam int NCON = 7;
   localparam int C_WW = 0;
   localparam int C_RW = 1;
   localparam int C_WR = 2;
   localparam int C_RR = 3;
   localparam int C_SY = 4;
   localparam int C_MI = 5;
   localparam int C_LA = 6;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_BCOUNT = 8'h08;
   localparam logic [7:0] OFS_ICOUNT = 8'h0c;
   localparam int CTRL_STRONG = 0;
   localparam logic CTRL_RESET = 1'b0;
   localparam int CNT_W = 16;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ORDER = 3'b010,
      ST_SYNC = 3'b100
   } state_t;
   typedef struct packed {
      logic ld_pending;
      logic st_pending;
      logic op_pending;
      logic err_pending;
   } mem_status_t;
   typedef struct packed {
      logic issue;
      logic load;
      logic store;
   } hold_t;
endpackage

// ==== hw/barrier_regs.sv ====
// Purpose: AHB-Lite slave holding control and showing status
// Assumes: single word transfers, zero wait states
// Notes: unmapped reads return zero, writes there are dropped
`timescale 1ns/10ps
module barrier_regs (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic strong_order,
   input wire logic [31:0] status_word,
   input wire logic [barrier_pkg::CNT_W-1:0] bcount,
   input wire logic [barrier_pkg::CNT_W-1:0] icount
);
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic ctrl_q;
   logic ctrl_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   wire addr_ok = hsel & htrans[1] & hready;
   wire ctrl_wr = wr_pend_q & (wr_addr_q == barrier_pkg::OFS_CTRL);
   wire [7:0] ofs = haddr[7:0];
   wire upper_zero = (haddr[31:8] == 24'h00_0000);
   wire [31:0] cnt_b = {{(32-barrier_pkg::CNT_W){1'b0}}, bcount};
   wire [31:0] cnt_i = {{(32-barrier_pkg::CNT_W){1'b0}}, icount};
   // write data lands one cycle after its address phase; reads bypass it
   assign ctrl_d = ctrl_wr ? hwdata[barrier_pkg::CTRL_STRONG] : ctrl_q;
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (upper_zero && ofs == barrier_pkg::OFS_CTRL) begin
         rdata_d[barrier_pkg::CTRL_STRONG] = ctrl_d;
      end else if (upper_zero && ofs == barrier_pkg::OFS_STATUS) begin
         rdata_d = status_word;
      end else if (upper_zero && ofs == barrier_pkg::OFS_BCOUNT) begin
         rdata_d = cnt_b;
      end else if (upper_zero && ofs == barrier_pkg::OFS_ICOUNT) begin
         rdata_d = cnt_i;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         ctrl_q <= barrier_pkg::CTRL_RESET;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_ok & hwrite & upper_zero;
         wr_addr_q <= ofs;
         ctrl_q <= ctrl_d;
         if (addr_ok && !hwrite) begin
            rdata_q <= rdata_d;
         end
      end
   end
   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign strong_order = ctrl_q;
endmodule

// ==== hw/barrier_unit.sv ====
// Purpose: decode barrier instructions and hold issue, loads and stores
// Assumes: memory status flags cover work issued before the barrier
// Notes: one barrier in flight; a second waits on barrier_ready
`timescale 1ns/10ps
module barrier_unit #(
   parameter logic [1:0] OP_MATCH = 2'h2,
   parameter logic [5:0] OP3_MATCH = 6'h28
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic dec_valid,
   input wire logic [31:0] dec_instr,
   input wire logic asi_sync_req,
   input wire barrier_pkg::mem_status_t mem_status,
   output logic barrier_ready,
   output logic illegal_exc,
   output logic sync_done,
   output barrier_pkg::hold_t hold
);
   logic strong_order;
   logic [3:0] order_mask;
   logic [2:0] compl_mask;
   logic [4:0] rs1_field;
   logic [4:0] rd_field;
   logic [1:0] op_field;
   logic [5:0] op3_field;
   logic is_barrier;
   logic bad_bits;
   logic take;
   logic accept;
   logic illegal;
   logic asi_take;
   logic start;
   logic [barrier_pkg::NCON-1:0] req;
   logic [barrier_pkg::NCON-1:0] eff;
   logic [barrier_pkg::NCON-1:0] met;
   logic [barrier_pkg::NCON-1:0] pend_q;
   logic [barrier_pkg::NCON-1:0] pend_d;
   barrier_pkg::hold_t hold_q;
   barrier_pkg::hold_t hold_d;
   barrier_pkg::state_t state_q;
   barrier_pkg::state_t state_d;
   logic ready_q;
   logic ready_d;
   logic illegal_q;
   logic sync_done_q;
   logic sync_done_d;
   logic [barrier_pkg::CNT_W-1:0] bcnt_q;
   logic [barrier_pkg::CNT_W-1:0] icnt_q;
   logic [31:0] status_word;
   logic ld_p;
   logic st_p;
   logic op_p;
   logic err_p;

   // register access
   barrier_regs u_regs (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .strong_order(strong_order),
      .status_word(status_word),
      .bcount(bcnt_q),
      .icount(icnt_q)
   );

   // instruction fields
   assign order_mask = dec_instr[barrier_pkg::MM_MSB:barrier_pkg::MM_LSB];
   assign compl_mask = dec_instr[barrier_pkg::CM_MSB:barrier_pkg::CM_LSB];
   assign rs1_field = dec_instr[barrier_pkg::RS1_MSB:barrier_pkg::RS1_LSB];
   assign rd_field = dec_instr[barrier_pkg::RD_MSB:barrier_pkg::RD_LSB];
   assign op_field = dec_instr[barrier_pkg::OP_MSB:barrier_pkg::OP_LSB];
   assign op3_field = dec_instr[barrier_pkg::OP3_MSB:barrier_pkg::OP3_LSB];

   // shared opcode with the ancillary state read, told apart by fields
   assign is_barrier = (op_field == OP_MATCH)
      && (op3_field == OP3_MATCH)
      && (rs1_field == barrier_pkg::RS1_BARRIER)
      && (rd_field == barrier_pkg::RD_BARRIER)
      && dec_instr[barrier_pkg::IMM_BIT]
      && !dec_instr[barrier_pkg::RSV_MSB];
   // bit 12 set already means ancillary read, so 11..7 decide here
   assign bad_bits = |dec_instr[barrier_pkg::RSV_MSB-1:barrier_pkg::RSV_LSB];

   // acceptance
   assign take = dec_valid & ready_q & is_barrier;
   assign accept = take & !bad_bits;
   assign illegal = take & bad_bits;
   assign asi_take = asi_sync_req & ready_q;
   assign start = accept | asi_take;

   // requested constraints, union of every selected bit
   assign req[barrier_pkg::C_WW] = accept & order_mask[3];
   assign req[barrier_pkg::C_RW] = accept & order_mask[2];
   assign req[barrier_pkg::C_WR] = accept & order_mask[1];
   assign req[barrier_pkg::C_RR] = accept & order_mask[0];
   // zero completion mask leaves only the ordering bits above
   assign req[barrier_pkg::C_SY] = (accept & compl_mask[2]) | asi_take;
   assign req[barrier_pkg::C_MI] = accept & compl_mask[1];
   assign req[barrier_pkg::C_LA] = accept & compl_mask[0];

   // strong ordering: three orderings free, the rest become full sync
   assign eff[barrier_pkg::C_WW] = req[barrier_pkg::C_WW] & !strong_order;
   assign eff[barrier_pkg::C_RW] = req[barrier_pkg::C_RW] & !strong_order;
   assign eff[barrier_pkg::C_RR] = req[barrier_pkg::C_RR] & !strong_order;
   assign eff[barrier_pkg::C_WR] = req[barrier_pkg::C_WR] & !strong_order;
   assign eff[barrier_pkg::C_MI] = req[barrier_pkg::C_MI] & !strong_order;
   assign eff[barrier_pkg::C_LA] = req[barrier_pkg::C_LA] & !strong_order;
   // promotion to sync is a stronger but legal realisation
   assign eff[barrier_pkg::C_SY] = req[barrier_pkg::C_SY]
      | (strong_order & (req[barrier_pkg::C_WR]
      | req[barrier_pkg::C_MI]
      | req[barrier_pkg::C_LA]));

   // own core only: no input from other processors takes part
   assign ld_p = mem_status.ld_pending;
   assign st_p = mem_status.st_pending;
   assign op_p = mem_status.op_pending;
   assign err_p = mem_status.err_pending;

   // release conditions
   assign met[barrier_pkg::C_WW] = !st_p;
   assign met[barrier_pkg::C_RW] = !ld_p;
   assign met[barrier_pkg::C_WR] = !st_p;
   assign met[barrier_pkg::C_RR] = !ld_p;
   // visibility suffices, no wait for the external memory write
   assign met[barrier_pkg::C_SY] = !op_p & !err_p;
   assign met[barrier_pkg::C_MI] = !ld_p & !st_p;
   assign met[barrier_pkg::C_LA] = !st_p;

   // one pending bit per constraint
   genvar k;
   generate
      for (k = 0; k < barrier_pkg::NCON; k++) begin : g_con
         assign pend_d[k] = (pend_q[k] | eff[k]) & !met[k];
      end
   endgenerate

   // holds toward issue and the load/store unit
   assign hold_d.store = pend_d[barrier_pkg::C_WW]
      | pend_d[barrier_pkg::C_RW]
      | pend_d[barrier_pkg::C_MI]
      | pend_d[barrier_pkg::C_SY];
   assign hold_d.load = pend_d[barrier_pkg::C_WR]
      | pend_d[barrier_pkg::C_RR]
      | pend_d[barrier_pkg::C_MI]
      | pend_d[barrier_pkg::C_LA]
      | pend_d[barrier_pkg::C_SY];
   assign hold_d.issue = pend_d[barrier_pkg::C_SY];
   assign ready_d = !(|pend_d);
   assign sync_done_d = pend_q[barrier_pkg::C_SY] & !pend_d[barrier_pkg::C_SY];

   // state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         barrier_pkg::ST_IDLE: begin
            if (pend_d[barrier_pkg::C_SY]) begin
               state_d = barrier_pkg::ST_SYNC;
            end else if (|pend_d) begin
               state_d = barrier_pkg::ST_ORDER;
            end
         end
         barrier_pkg::ST_ORDER: begin
            if (!(|pend_d)) begin
               state_d = barrier_pkg::ST_IDLE;
            end
         end
         barrier_pkg::ST_SYNC: begin
            if (!pend_d[barrier_pkg::C_SY]) begin
               state_d = (|pend_d) ? barrier_pkg::ST_ORDER : barrier_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = barrier_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_q <= '0;
         hold_q <= '0;
         state_q <= barrier_pkg::ST_IDLE;
         ready_q <= 1'b1;
         illegal_q <= 1'b0;
         sync_done_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         hold_q <= hold_d;
         state_q <= state_d;
         ready_q <= ready_d;
         illegal_q <= illegal;
         sync_done_q <= sync_done_d;
      end
   end

   // barrier and exception counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bcnt_q <= '0;
         icnt_q <= '0;
      end else begin
         if (accept) begin
            bcnt_q <= bcnt_q + 1'b1;
         end
         if (illegal) begin
            icnt_q <= icnt_q + 1'b1;
         end
      end
   end

   assign status_word = {16'h0000, 3'b000, state_q, pend_q, hold_q};
   assign hold = hold_q;
   assign barrier_ready = ready_q;
   assign illegal_exc = illegal_q;
   assign sync_done = sync_done_q;

   // checks
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_ww_start;
      accept && !strong_order && order_mask[3] && st_p;
   endsequence
   sequence s_sync_wait;
      pend_q[barrier_pkg::C_SY] && (op_p || err_p);
   endsequence
   sequence s_sync_free;
      pend_q[barrier_pkg::C_SY] && !op_p && !err_p;
   endsequence
   sequence s_ord_only;
      accept && !strong_order && compl_mask == 3'h0 && !asi_sync_req;
   endsequence

   a_ww_store_hold:
   assert property (s_ww_start |=> hold_q.store && !ready_q)
      else $error("earlier stores not ordered before later stores");
   a_rw_store_hold:
   assert property (accept && !strong_order && order_mask[2] && ld_p
      |=> hold_q.store)
      else $error("earlier loads not ordered before later stores");
   a_wr_load_hold:
   assert property (accept && !strong_order && order_mask[1] && st_p
      |=> hold_q.load)
      else $error("earlier stores not ordered before later loads");
   a_rr_load_hold:
   assert property (accept && !strong_order && order_mask[0] && ld_p && !compl_mask[2]
      && !asi_sync_req |=> hold_q.load && !hold_q.issue)
      else $error("earlier loads not ordered before later loads");
   a_sync_issue_hold:
   assert property (accept && compl_mask[2] && op_p
      |=> hold_q.issue && state_q == barrier_pkg::ST_SYNC)
      else $error("sync barrier did not hold issue");
   a_access_issue_barrier_hold:
   assert property (accept && !strong_order && compl_mask[1] && ld_p
      |=> hold_q.load && hold_q.store)
      else $error("memory issue barrier did not hold memory work");
   a_nop_no_hold:
   assert property (accept && order_mask == 4'h0 && compl_mask == 3'h0 && !asi_sync_req
      |=> hold_q == '0 && ready_q)
      else $error("empty barrier was not a no-operation");
   a_illegal_pulse:
   assert property (take && bad_bits |=> illegal_exc && bcnt_q == $past(bcnt_q))
      else $error("reserved bits did not raise an exception");
   a_legacy_strong:
   assert property (accept && strong_order && order_mask == barrier_pkg::LEGACY_WB_MM
      && compl_mask == 3'h0 && !asi_sync_req |=> hold_q == '0)
      else $error("strong ordering did not drop write ordering");
   a_sync_wait_hold:
   assert property (s_sync_wait |=> hold_q.issue)
      else $error("issue released before outstanding work drained");
   a_sync_release:
   assert property (s_sync_free |=> !hold_q.issue ##0 sync_done)
      else $error("sync did not release once drained");
   a_asi_sync:
   assert property (asi_take && op_p |=> state_q == barrier_pkg::ST_SYNC)
      else $error("sync address space did not force synchronization");
   a_union_holds:
   assert property (accept && !strong_order && order_mask[3] && order_mask[0]
      && st_p && ld_p |=> hold_q.load && hold_q.store)
      else $error("combined bits did not enforce the union");
   a_partial_no_issue:
   assert property (s_ord_only |=> !hold_q.issue)
      else $error("zero completion mask held instruction issue");
   a_legacy_weak:
   assert property (s_ord_only ##0 (order_mask == barrier_pkg::LEGACY_WB_MM && st_p)
      |=> hold_q.store && !hold_q.load)
      else $error("legacy write barrier did not order stores alone");
   a_wr_load_only:
   assert property (s_ord_only ##0 (order_mask == 4'h2 && st_p)
      |=> hold_q.load && !hold_q.store)
      else $error("write-read ordering held the wrong class");
   a_la_load_hold:
   assert property (accept && !strong_order && compl_mask[0] && st_p |=> hold_q.load)
      else $error("same-address barrier did not hold later loads");
   a_ww_wait_hold:
   assert property (pend_q[barrier_pkg::C_WW] && st_p |=> hold_q.store && !ready_q)
      else $error("later stores released before earlier stores visible");
   a_rw_wait_hold:
   assert property (pend_q[barrier_pkg::C_RW] && ld_p |=> hold_q.store)
      else $error("later stores released before earlier loads performed");
   a_wr_wait_hold:
   assert property (pend_q[barrier_pkg::C_WR] && st_p |=> hold_q.load)
      else $error("later loads released before earlier stores visible");
   a_rr_wait_hold:
   assert property (pend_q[barrier_pkg::C_RR] && ld_p |=> hold_q.load)
      else $error("later loads released before earlier loads performed");
   a_mi_wait_hold:
   assert property (pend_q[barrier_pkg::C_MI] && (ld_p || st_p)
      |=> hold_q.load && hold_q.store)
      else $error("memory work released before earlier memory work done");
   a_la_wait_hold:
   assert property (pend_q[barrier_pkg::C_LA] && st_p |=> hold_q.load)
      else $error("later loads released before earlier stores complete");
   a_strong_sync:
   assert property (accept && strong_order && order_mask[1] && op_p |=> hold_q.issue)
      else $error("strong ordering did not promote write-read to sync");
   a_illegal_no_hold:
   assert property (take && bad_bits && !asi_sync_req |=> hold_q == '0 && ready_q)
      else $error("illegal barrier set a hold");
   a_sync_done_once:
   assert property (sync_done |=> !sync_done)
      else $error("sync done lasted more than one cycle");
endmodule

// ==== verif/mem_model.sv ====
// Purpose: load/store side stand-in that raises pending flags for a set time
// Assumes: lat fields are cycles {ld, st, op, err}, one byte each
// Notes: flags load on start and count down one per clock
`timescale 1ns/10ps
module mem_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic [31:0] lat,
   output barrier_pkg::mem_status_t mem_status
);
   logic [7:0] cnt_q [4];
   logic [7:0] cnt_d [4];
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         cnt_d[i] = (cnt_q[i] != 8'h00) ? cnt_q[i] - 8'h01 : 8'h00;
         if (start) begin
            cnt_d[i] = lat[i*8 +: 8];
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      for (int i = 0; i < 4; i++) begin
         cnt_q[i] <= !hresetn ? 8'h00 : cnt_d[i];
      end
   end
   assign mem_status = barrier_pkg::mem_status_t'({cnt_q[3] != 8'h00, cnt_q[2] != 8'h00,
      cnt_q[1] != 8'h00, cnt_q[0] != 8'h00});
endmodule

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the barrier unit
// Assumes: mem_model stands in for the load/store side
// Notes: release counts are clocks from the taking edge to barrier_ready
`timescale 1ns/10ps
module testbench;
   logic hclk, hresetn, hwrite, hready, hreadyout, hresp, dec_valid, asi_sync_req;
   logic barrier_ready, illegal_exc, sync_done, start;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, dec_instr, lat, rd;
   barrier_pkg::mem_status_t mem_status;
   barrier_pkg::hold_t hold;
   int num_errors, checked;
   int cycles = 0;
   assign hready = hreadyout;
   barrier_unit barrier_unit_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .dec_valid(dec_valid), .dec_instr(dec_instr),
      .asi_sync_req(asi_sync_req), .mem_status(mem_status), .barrier_ready(barrier_ready),
      .illegal_exc(illegal_exc), .sync_done(sync_done), .hold(hold)
   );
   mem_model mem_model_inst (
      .hclk(hclk), .hresetn(hresetn), .start(start), .lat(lat), .mem_status(mem_status)
   );
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task print_verdict;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict;
      end
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] bar(input logic [5:0] rsv, input logic [2:0] cm,
      input logic [3:0] mm);
      return {2'h2, 5'h00, 6'h28, 5'h0f, 1'b1, rsv, cm, mm};
   endfunction
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // pending flags start one clock before the barrier is taken
   task run(input logic [31:0] i, input logic a, input logic [31:0] l, input logic [2:0] eh,
      input logic ei, input logic es, input int en);
      int n;
      @(posedge hclk);
      start <= 1'b1;
      lat <= l;
      @(posedge hclk);
      start <= 1'b0;
      dec_valid <= !a;
      asi_sync_req <= a;
      dec_instr <= i;
      @(posedge hclk);
      dec_valid <= 1'b0;
      asi_sync_req <= 1'b0;
      #1;
      chk("hold", {29'h0, hold}, {29'h0, eh});
      chk("ready", {31'h0, barrier_ready}, {31'h0, eh == 3'h0});
      chk("illegal", {31'h0, illegal_exc}, {31'h0, ei});
      n = 0;
      while (barrier_ready !== 1'b1 && n < 300) begin
         @(posedge hclk);
         #1;
         n++;
      end
      chk("release cycles", n, en);
      chk("sync done", {31'h0, sync_done}, {31'h0, es});
      @(posedge hclk);
      #1;
      chk("pulse end", {30'h0, illegal_exc, sync_done}, 32'h0);
   endtask
   task t_regs;
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      ahb(1'b0, 32'h8, 32'h0);
      chk("bcount reset", rd, 32'h0);
      ahb(1'b0, 32'h4, 32'h0);
      chk("status idle", rd, 32'h0000_0400);
      ahb(1'b1, 32'h0, 32'h1);
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl rw", rd, 32'h1);
      ahb(1'b1, 32'h40, 32'hffff_ffff);
      ahb(1'b0, 32'h40, 32'h0);
      chk("unmapped", rd, 32'h0);
      ahb(1'b1, 32'h0, 32'h0);
   endtask
   task t_order;
      run(bar(6'h0, 3'h0, 4'h8), 1'b0, 32'h0003_0000, 3'b001, 1'b0, 1'b0, 3);
      run(bar(6'h0, 3'h0, 4'h8), 1'b0, 32'h0300_0000, 3'b000, 1'b0, 1'b0, 0);
      run(bar(6'h0, 3'h0, 4'h4), 1'b0, 32'h0400_0000, 3'b001, 1'b0, 1'b0, 4);
      run(bar(6'h0, 3'h0, 4'h2), 1'b0, 32'h0002_0000, 3'b010, 1'b0, 1'b0, 2);
      run(bar(6'h0, 3'h0, 4'h1), 1'b0, 32'h0500_0000, 3'b010, 1'b0, 1'b0, 5);
      run(bar(6'h0, 3'h0, 4'hf), 1'b0, 32'h0206_0000, 3'b011, 1'b0, 1'b0, 6);
   endtask
   task t_complete;
      run(bar(6'h0, 3'h4, 4'h0), 1'b0, 32'h0000_0203, 3'b111, 1'b0, 1'b1, 3);
      run(bar(6'h0, 3'h2, 4'h0), 1'b0, 32'h0204_0000, 3'b011, 1'b0, 1'b0, 4);
      run(bar(6'h0, 3'h1, 4'h0), 1'b0, 32'h0003_0000, 3'b010, 1'b0, 1'b0, 3);
      run(bar(6'h0, 3'h0, 4'h0), 1'b0, 32'h0303_0303, 3'b000, 1'b0, 1'b0, 0);
   endtask
   task t_illegal;
      for (int b = 0; b < 5; b++) begin
         run(bar(6'h01 << b, 3'h0, 4'h8), 1'b0, 32'h0003_0000, 3'b000, 1'b1, 1'b0, 0);
      end
      run(bar(6'h20, 3'h0, 4'h8), 1'b0, 32'h0003_0000, 3'b000, 1'b0, 1'b0, 0);
      run(bar(6'h0, 3'h0, 4'h8) ^ 32'h0000_4000, 1'b0, 32'h0003_0000, 3'b000, 1'b0, 1'b0,
         0);
      ahb(1'b0, 32'hc, 32'h0);
      chk("illegal count", rd, 32'h5);
      ahb(1'b0, 32'h8, 32'h0);
      chk("barrier count", rd, 32'ha);
   endtask
   task t_strong;
      ahb(1'b1, 32'h0, 32'h1);
      run(bar(6'h0, 3'h0, 4'h8), 1'b0, 32'h0003_0000, 3'b000, 1'b0, 1'b0, 0);
      run(bar(6'h0, 3'h0, 4'h2), 1'b0, 32'h0003_0500, 3'b111, 1'b0, 1'b1, 5);
      ahb(1'b1, 32'h0, 32'h0);
      run(32'h0, 1'b1, 32'h0000_0004, 3'b111, 1'b0, 1'b1, 4);
   endtask
   // reset in the middle of a sync barrier clears holds and control
   task t_reset;
      ahb(1'b1, 32'h0, 32'h1);
      @(posedge hclk);
      start <= 1'b1;
      lat <= 32'h0000_0800;
      @(posedge hclk);
      start <= 1'b0;
      dec_valid <= 1'b1;
      dec_instr <= bar(6'h0, 3'h4, 4'h0);
      @(posedge hclk);
      dec_valid <= 1'b0;
      #1;
      chk("sync held", {29'h0, hold}, 32'h7);
      @(posedge hclk);
      hresetn <= 1'b0;
      #1;
      chk("in reset", {26'h0, hold, barrier_ready, illegal_exc, sync_done}, 32'h0000_0004);
      @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      chk("after release", {26'h0, hold, barrier_ready, illegal_exc, sync_done}, 32'h0000_0004);
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl after reset", rd, 32'h0);
      run(bar(6'h0, 3'h0, 4'h8), 1'b0, 32'h0003_0000, 3'b001, 1'b0, 1'b0, 3);
   endtask
   initial begin
      hresetn = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      dec_valid = 1'b0;
      asi_sync_req = 1'b0;
      dec_instr = 32'h0;
      start = 1'b0;
      lat = 32'h0;
      num_errors = 0;
      checked = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_order;
      t_complete;
      t_illegal;
      t_strong;
      t_reset;
      print_verdict;
   end
endmodule
